/* File: dv/ssm_chk.sv */
// Port-level assertions for the safety stop monitor
`timescale 1ns/1ps
`default_nettype none
module ssm_chk
  import ssm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stop_channel_one_in_i,
  input wire logic stop_channel_two_in_i,
  input wire logic safety_circuit_fault_i,
  input wire logic running_i,
  input wire logic [4:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic irq_o,
  input wire logic drive_enable_o,
  input wire logic safe_monitor_o,
  input wire logic run_terminal_o,
  input wire logic term_b_o,
  input wire logic term_c_o,
  input wire logic [2:0] panel_o
);
  logic [1:0] age_reg;
  logic [5:0] ch_reg;
  logic f_reg;
  logic run_reg;
  logic [7:0] sa_reg;
  logic [7:0] sb_reg;
  logic ok;
  logic e_sf;
  logic e_nf;
  // Pins reach the outputs three edges late, the fault input one
  assign ok = age_reg == 2'd3;
  assign e_sf = !ch_reg[4] && !ch_reg[5] && !f_reg;
  assign e_nf = !f_reg && ch_reg[4] == ch_reg[5];
  always_ff @(posedge clk_i) begin
    ch_reg <= {ch_reg[3:0], stop_channel_two_in_i, stop_channel_one_in_i};
    f_reg <= safety_circuit_fault_i;
    run_reg <= running_i;
    if (rst_i) begin
      age_reg <= 2'd0;
    end else if (!ok) begin
      age_reg <= age_reg + 2'd1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sa_reg <= SSM_SEL_A_RESET;
      sb_reg <= SSM_SEL_B_RESET;
    end else if (wr_i && addr_i == 5'(SSM_OFS_SEL_A)) begin
      sa_reg <= wdata_i[7:0];
    end else if (wr_i && addr_i == 5'(SSM_OFS_SEL_B)) begin
      sb_reg <= wdata_i[7:0];
    end
  end
  function automatic logic tv(logic [7:0] s, logic sf, logic nf, logic dv);
    case (s)
      SSM_FN_SAFE_POS: return sf;
      SSM_FN_SAFE_NEG: return !sf;
      SSM_FN_NOFAULT_POS: return nf;
      SSM_FN_NOFAULT_NEG: return !nf;
      default: return dv;
    endcase
  endfunction
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_drive; ok |-> drive_enable_o == (ch_reg[4] && ch_reg[5] && !f_reg); endproperty
  property p_safe; ok |-> safe_monitor_o == e_sf; endproperty
  property p_safe_off; drive_enable_o |-> !safe_monitor_o; endproperty
  property p_mis; ok && ch_reg[4] != ch_reg[5] |-> !drive_enable_o && !safe_monitor_o; endproperty
  property p_pfault; ok && f_reg |-> panel_o == SSM_PANEL_FAULT; endproperty
  property p_psafe; ok && e_sf |-> panel_o == SSM_PANEL_SAFE_STOP; endproperty
  property p_run; ok && $stable(sa_reg) |-> run_terminal_o == tv(sa_reg, e_sf, e_nf, run_reg);
  endproperty
  property p_term_b; ok && $stable(sb_reg) |-> term_b_o == tv(sb_reg, e_sf, e_nf, 1'b0);
  endproperty
  a_drive: assert property (p_drive) else $error("drive enable wrong");
  a_safe: assert property (p_safe) else $error("safe monitor wrong");
  a_safe_off: assert property (p_safe_off) else $error("safe while enabled");
  a_mis: assert property (p_mis) else $error("mismatch outputs on");
  a_pfault: assert property (p_pfault) else $error("no fault code");
  a_psafe: assert property (p_psafe) else $error("no safe stop shown");
  a_run: assert property (p_run) else $error("run terminal wrong");
  a_term_b: assert property (p_term_b) else $error("terminal b wrong");
  c_en: cover property (ok && drive_enable_o);
  c_safe: cover property (ok && safe_monitor_o);
  c_irq: cover property (irq_o);
endmodule
bind ssm_top ssm_chk u_chk (.*);
`default_nettype wire

/* File: dv/ssm_relay.sv */
// Behavioural safety relay driving the two stop channels
`timescale 1ns/1ps
`default_nettype none
module ssm_relay (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic [1:0] open_i,
  output logic ch1_o,
  output logic ch2_o
);
  logic [1:0] lag_reg;
  always_ff @(posedge clk_i) begin
    lag_reg <= ~open_i;
  end
  // Shorted contact reads high; slow mode lags a cycle like a sluggish contact
  assign ch1_o = slow_i ? lag_reg[0] : ~open_i[0];
  assign ch2_o = slow_i ? lag_reg[1] : ~open_i[1];
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the safety stop monitor
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ssm_pkg::*;
;
  logic clk_i = 0, rst_i = 1, safety_circuit_fault_i = 0, running_i = 0, wr_i = 0, rd_i = 0;
  logic stop_channel_one_in_i, stop_channel_two_in_i, slow = 0, irq_o, drive_enable_o;
  logic safe_monitor_o, run_terminal_o, term_b_o, term_c_o;
  logic [1:0] open_req = 0;
  logic [4:0] addr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o, rv, rn, seed = 32'd91656;
  logic [2:0] panel_o;
  logic [7:0] sel [3] = '{SSM_SEL_A_RESET, SSM_SEL_B_RESET, SSM_SEL_C_RESET};
  logic [7:0] codes [5] = '{SSM_FN_RUN, SSM_FN_SAFE_POS, SSM_FN_SAFE_NEG,
                            SSM_FN_NOFAULT_POS, SSM_FN_NOFAULT_NEG};
  int err_total = 0, samples_checked = 0, cyc = 0;
  initial forever #20 clk_i = ~clk_i;
  ssm_relay rly (.clk_i(clk_i), .slow_i(slow), .open_i(open_req),
                 .ch1_o(stop_channel_one_in_i), .ch2_o(stop_channel_two_in_i));
  ssm_top uut (.*);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic tv(logic [7:0] s, logic sf, logic nf, logic dv);
    case (s)
      SSM_FN_SAFE_POS: return sf;
      SSM_FN_SAFE_NEG: return !sf;
      SSM_FN_NOFAULT_POS: return nf;
      SSM_FN_NOFAULT_NEG: return !nf;
      default: return dv;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge clk_i);
    wr_i <= 0;
    rd_i <= 0;
    #1 rv = rdata_o;
  endtask
  task automatic wsel(input int i, input logic [7:0] v);
    bus(1, 5'(i * 4), {24'h0, v});
    sel[i] = v;
  endtask
  task automatic apply(input logic [1:0] o, input logic f, input logic r);
    logic sf, nf;
    @(posedge clk_i);
    open_req <= o;
    safety_circuit_fault_i <= f;
    running_i <= r;
    repeat (5) @(posedge clk_i);
    #1;
    sf = o == 2'b11 && !f;
    nf = !f && o[0] == o[1];
    chk(drive_enable_o, o == 2'b00 && !f);
    chk(safe_monitor_o, sf);
    chk(panel_o, f ? SSM_PANEL_FAULT : sf ? SSM_PANEL_SAFE_STOP : SSM_PANEL_NONE);
    chk(run_terminal_o, tv(sel[0], sf, nf, r));
    chk(term_b_o, tv(sel[1], sf, nf, 0));
    chk(term_c_o, tv(sel[2], sf, nf, 0));
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    // Status word skipped: it already follows the pins here
    for (int i = 0; i < 6; i++) begin
      if (i != 3) begin
        bus(0, 5'(i * 4), 0);
        chk(rv, (i < 3) ? {24'h0, sel[i % 3]} : 32'h0);
      end
    end
    apply(2'b00, 0, 1);
    bus(1, SSM_OFS_IRQ_STAT, 7);
    bus(1, SSM_OFS_IRQ_MASK, 1 << SSM_IRQ_STOP);
    apply(2'b11, 0, 0);
    chk(irq_o, 1);
    bus(0, 5'(SSM_OFS_STATUS), 0);
    chk(rv, {22'h0, SSM_PANEL_SAFE_STOP, SSM_ST_SAFE_STOP, 3'b011});
    apply(2'b01, 0, 0);
    bus(1, SSM_OFS_IRQ_STAT, 1 << SSM_IRQ_STOP);
    bus(0, SSM_OFS_IRQ_STAT, 0);
    chk(rv, 1 << SSM_IRQ_MISMATCH);
    chk(irq_o, 0);
    for (int i = 0; i < 5; i++) begin
      for (int s = 0; s < 3; s++) wsel(s, codes[(i + s) % 5]);
      for (int k = 0; k < 5; k++) apply(k[1:0], k == 4, k[0]);
    end
    // Own variable, since the bus task overwrites rv
    for (int n = 0; n < 60; n++) begin
      rn = xs();
      slow <= rn[8];
      if (rn[11:9] == 0) wsel(rn[13:12] % 3, codes[rn[16:14] % 5]);
      apply(rn[1:0], rn[2] & rn[5], rn[4]);
    end
    @(posedge clk_i);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    #1;
    chk(drive_enable_o, 0);
    chk(safe_monitor_o, 0);
    chk(panel_o, SSM_PANEL_NONE);
    sel = '{SSM_SEL_A_RESET, SSM_SEL_B_RESET, SSM_SEL_C_RESET};
    bus(0, 5'(SSM_OFS_SEL_A), 0);
    chk(rv, {24'h0, SSM_SEL_A_RESET});
    apply(2'b00, 0, 1);
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: rtl/ssm_pkg.sv */
// Shared constants and types for the safety stop monitor
package ssm_pkg;

  // Output-function codes for the terminal selects
  localparam logic [7:0] SSM_FN_RUN = 8'h00;
  localparam logic [7:0] SSM_FN_SAFE_POS = 8'h50;
  localparam logic [7:0] SSM_FN_NOFAULT_POS = 8'h51;
  localparam logic [7:0] SSM_FN_SAFE_NEG = 8'hB4;
  localparam logic [7:0] SSM_FN_NOFAULT_NEG = 8'hB5;

  // Values after initialisation of the three selects
  localparam logic [7:0] SSM_SEL_A_RESET = SSM_FN_RUN;
  localparam logic [7:0] SSM_SEL_B_RESET = SSM_FN_RUN;
  localparam logic [7:0] SSM_SEL_C_RESET = SSM_FN_RUN;

  // Register byte offsets
  localparam logic [3:0] SSM_OFS_SEL_A = 4'h0;
  localparam logic [3:0] SSM_OFS_SEL_B = 4'h4;
  localparam logic [3:0] SSM_OFS_SEL_C = 4'h8;
  localparam logic [3:0] SSM_OFS_STATUS = 4'hC;
  localparam logic [4:0] SSM_OFS_IRQ_STAT = 5'h10;
  localparam logic [4:0] SSM_OFS_IRQ_MASK = 5'h14;

  // Interrupt status bit positions
  localparam int SSM_IRQ_FAULT = 0;
  localparam int SSM_IRQ_STOP = 1;
  localparam int SSM_IRQ_MISMATCH = 2;
  localparam int SSM_IRQ_W = 3;

  localparam int SSM_SYNC_STAGES = 2;

  // Panel indication codes
  typedef enum logic [2:0] {
    SSM_PANEL_NONE = 3'b001,
    SSM_PANEL_SAFE_STOP = 3'b010,
    SSM_PANEL_FAULT = 3'b100
  } ssm_panel_t;

  typedef enum logic [3:0] {
    SSM_ST_ENABLED = 4'b0001,
    SSM_ST_SAFE_STOP = 4'b0010,
    SSM_ST_FAULT = 4'b0100,
    SSM_ST_MISMATCH = 4'b1000
  } ssm_state_t;

  typedef struct packed {
    logic drive_enable;
    logic safe_state;
    logic no_fault;
  } ssm_status_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ssm_bus_req_t;

endpackage

/* File: rtl/ssm_sync.sv */
// Two-stage level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ssm_sync
  import ssm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);

  logic [SSM_SYNC_STAGES-1:0] stage_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[SSM_SYNC_STAGES-2:0], d_i};
    end
  end

  assign q_o = stage_reg[SSM_SYNC_STAGES-1];

endmodule
`default_nettype wire

/* File: rtl/ssm_top.sv */
// Safety stop monitor: channel evaluation, status outputs, terminal mapping
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ssm_top
  import ssm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stop_channel_one_in_i,
  input wire logic stop_channel_two_in_i,
  input wire logic safety_circuit_fault_i,
  input wire logic running_i,
  input wire logic [4:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic drive_enable_o,
  output logic safe_monitor_o,
  output logic run_terminal_o,
  output logic term_b_o,
  output logic term_c_o,
  output logic [2:0] panel_o
);

  ssm_bus_req_t req;
  logic ch1_short;
  logic ch2_short;
  ssm_state_t state_next;
  ssm_status_t stat_next;
  ssm_status_t stat_reg;
  ssm_panel_t panel_next;
  ssm_panel_t panel_reg;
  logic [7:0] sel_a_reg;
  logic [7:0] sel_b_reg;
  logic [7:0] sel_c_reg;
  logic [SSM_IRQ_W-1:0] irq_stat_reg;
  logic [SSM_IRQ_W-1:0] irq_mask_reg;
  logic [SSM_IRQ_W-1:0] irq_event;
  ssm_state_t state_reg;
  logic [2:0] term_next;
  logic [2:0] term_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Input high means the channel is shorted to common
  ssm_sync u_sync_one (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(stop_channel_one_in_i),
    .q_o(ch1_short)
  );

  ssm_sync u_sync_two (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(stop_channel_two_in_i),
    .q_o(ch2_short)
  );

  // Terminal driven by one select code; default falls back to the fallback signal
  function automatic logic map_term(input logic [7:0] code, input logic fallback,
                                    input ssm_status_t s);
    case (code)
      SSM_FN_SAFE_POS: map_term = s.safe_state;
      SSM_FN_SAFE_NEG: map_term = ~s.safe_state;
      SSM_FN_NOFAULT_POS: map_term = s.no_fault;
      SSM_FN_NOFAULT_NEG: map_term = ~s.no_fault;
      default: map_term = fallback;
    endcase
  endfunction

  // Decision table; synchronised channels lag the pins by two cycles
  always_comb begin
    state_next = SSM_ST_SAFE_STOP;
    case ({ch1_short, ch2_short})
      2'b11: state_next = SSM_ST_ENABLED;
      2'b00: state_next = SSM_ST_SAFE_STOP;
      default: state_next = SSM_ST_MISMATCH;
    endcase
    if (safety_circuit_fault_i && state_next != SSM_ST_MISMATCH) begin
      state_next = SSM_ST_FAULT;
    end
  end

  always_comb begin
    stat_next = '0;
    panel_next = SSM_PANEL_NONE;
    case (state_next)
      SSM_ST_ENABLED: begin
        stat_next.drive_enable = 1'b1;
        stat_next.no_fault = 1'b1;
      end
      SSM_ST_SAFE_STOP: begin
        stat_next.safe_state = 1'b1;
        stat_next.no_fault = 1'b1;
        panel_next = SSM_PANEL_SAFE_STOP;
      end
      SSM_ST_FAULT: begin
        panel_next = SSM_PANEL_FAULT;
      end
      SSM_ST_MISMATCH: begin
        stat_next = '0;
      end
      default: begin
        stat_next = '0;
      end
    endcase
    // Mismatch has no fault state, so a fault there only reaches the panel
    if (safety_circuit_fault_i) begin
      panel_next = SSM_PANEL_FAULT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= SSM_ST_SAFE_STOP;
      stat_reg <= '0;
      panel_reg <= SSM_PANEL_NONE;
    end else begin
      state_reg <= state_next;
      stat_reg <= stat_next;
      panel_reg <= panel_next;
    end
  end

  // Terminal mapping; a high output means the transistor conducts
  always_comb begin
    term_next[0] = map_term(sel_a_reg, running_i, stat_next);
    term_next[1] = map_term(sel_b_reg, 1'b0, stat_next);
    term_next[2] = map_term(sel_c_reg, 1'b0, stat_next);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_reg <= '0;
    end else begin
      term_reg <= term_next;
    end
  end

  // Select registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_a_reg <= SSM_SEL_A_RESET;
      sel_b_reg <= SSM_SEL_B_RESET;
      sel_c_reg <= SSM_SEL_C_RESET;
    end else if (req.wr) begin
      if (req.addr == {1'b0, SSM_OFS_SEL_A}) begin
        sel_a_reg <= req.wdata[7:0];
      end
      if (req.addr == {1'b0, SSM_OFS_SEL_B}) begin
        sel_b_reg <= req.wdata[7:0];
      end
      if (req.addr == {1'b0, SSM_OFS_SEL_C}) begin
        sel_c_reg <= req.wdata[7:0];
      end
    end
  end

  // Events on entering each stop condition
  assign irq_event[SSM_IRQ_FAULT] = (state_next == SSM_ST_FAULT) && (state_reg != SSM_ST_FAULT);
  assign irq_event[SSM_IRQ_STOP] =
      (state_next == SSM_ST_SAFE_STOP) && (state_reg != SSM_ST_SAFE_STOP);
  assign irq_event[SSM_IRQ_MISMATCH] =
      (state_next == SSM_ST_MISMATCH) && (state_reg != SSM_ST_MISMATCH);

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= '0;
    end else if (req.wr && req.addr == SSM_OFS_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~req.wdata[SSM_IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_reg <= '0;
    end else if (req.wr && req.addr == SSM_OFS_IRQ_MASK) begin
      irq_mask_reg <= req.wdata[SSM_IRQ_W-1:0];
    end
  end

  // Registered, so the line follows status by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data valid in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else if (req.rd) begin
      case (req.addr)
        {1'b0, SSM_OFS_SEL_A}: rdata_reg <= {24'h000000, sel_a_reg};
        {1'b0, SSM_OFS_SEL_B}: rdata_reg <= {24'h000000, sel_b_reg};
        {1'b0, SSM_OFS_SEL_C}: rdata_reg <= {24'h000000, sel_c_reg};
        {1'b0, SSM_OFS_STATUS}: rdata_reg <= {22'h0, panel_reg, state_reg,
                                              stat_reg.drive_enable,
                                              stat_reg.safe_state, stat_reg.no_fault};
        SSM_OFS_IRQ_STAT: rdata_reg <= {29'h0, irq_stat_reg};
        SSM_OFS_IRQ_MASK: rdata_reg <= {29'h0, irq_mask_reg};
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign drive_enable_o = stat_reg.drive_enable;
  assign safe_monitor_o = stat_reg.safe_state;
  assign run_terminal_o = term_reg[0];
  assign term_b_o = term_reg[1];
  assign term_c_o = term_reg[2];
  assign panel_o = panel_reg;

endmodule
`default_nettype wire
